// File: src/framer_defines.svh
// Constants for the hopping code word framer
`ifndef FRAMER_DEFINES_SVH
`define FRAMER_DEFINES_SVH
`define CLK_PERIOD_NS     10
`define TE_US             400
`define CARRIER_PERIOD_NS 25000
`define TIMEOUT_MS        25000
`define SEED_DELAY_WORDS  28
`define PREAMBLE_TE       8'h17
`define HEADER_TE         8'h0a
`define BIT_TE            8'h03
`define GUARD_TE          8'h27
`define VLOW_IDX          7'h40
`define CRC_LO_IDX        7'h41
`define LAST_IDX          7'h42
`define ENC_BITS          32
`define SER_SHORT         28
`define MIN_WORDS         10'h002
`define SEED_IMM_CODE     4'h9
`define SEED_DLY_CODE     4'h3
`define CTR_B_FIRST       4'h8
`endif

// File: src/framer_pkg.sv
// Types for the hopping code word framer
package framer_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_REQ, ST_WAIT, ST_PRE, ST_HDR, ST_DATA, ST_GUARD, ST_TOUT
  } fr_state_t;
endpackage

// File: src/hopping_code_word_framer.sv
// Code word framer: sequencing, fields, check bits, shutoff and LED
`timescale 1ns/100ps
`include "framer_defines.svh"

module hopping_code_word_framer
  import framer_pkg::*;
#(
  parameter int TE_US            = `TE_US,
  parameter int TIMEOUT_MS       = `TIMEOUT_MS,
  parameter int TICK_CYC         = 1000000 / `CLK_PERIOD_NS,
  parameter int SEED_DELAY_WORDS = `SEED_DELAY_WORDS
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // Button and low voltage pins
  input  wire logic        button_in_0_i,
  input  wire logic        button_in_1_i,
  input  wire logic        button_in_2_i,
  input  wire logic        button_in_3_i,
  input  wire logic        low_voltage_i,
  // Configuration
  input  wire logic        independent_counter_select_i,
  input  wire logic        blank_alternate_word_i,
  input  wire logic        auto_shutoff_enable_i,
  input  wire logic        wide_serial_select_i,
  input  wire logic        seed_enable_i,
  input  wire logic        user_bit_first_i,
  input  wire logic        user_bit_second_i,
  input  wire logic        counter_wrap_record_i,
  input  wire logic [31:0] serial_number_i,
  input  wire logic [15:0] sync_count_a_i,
  input  wire logic [15:0] sync_count_b_i,
  input  wire logic [31:0] seed_word_i,
  // Cipher side
  output logic             cipher_req_o,
  output logic      [31:0] plain_block_o,
  output logic             counter_b_sel_o,
  input  wire logic        cipher_valid_i,
  input  wire logic [31:0] cipher_data_i,
  output logic             cipher_ready_o,
  // Line side
  output logic             tx_data_o,
  output logic             led_o,
  output logic             power_hold_o,
  output logic             timeout_o
);

  localparam int TE_CYC   = TE_US * 1000 / `CLK_PERIOD_NS;
  localparam int CAR_HALF = `CARRIER_PERIOD_NS / 2 / `CLK_PERIOD_NS;

  function automatic logic use_ctr_b(input logic [3:0] c, input logic independent_counter_select);
    return independent_counter_select && (c >= `CTR_B_FIRST);
  endfunction

  function automatic logic [1:0] crc_step(input logic [1:0] c,
                                          input logic d);
    return {c[0] ^ d, c[0] ^ d ^ c[1]};
  endfunction

  fr_state_t   state_q;
  logic [3:0]  b_s1_q, b_s2_q, b_s3_q, btn_q;
  logic        v_s1_q, v_s2_q, v_s3_q, vlow_q;
  logic [3:0]  code_q, new_code;
  logic        go_req, abort, tout_hit, seed_now, active_tx;
  logic [31:0] te_cnt_q, car_cnt_q, tick_q, ms_q;
  logic [7:0]  unit_q, seg_len;
  logic        te_end, seg_end;
  logic [6:0]  bit_idx_q;
  logic [63:0] sr_q;
  logic [1:0]  crc_q;
  logic [9:0]  words_q;
  logic        slot_q, blank_q, car_q, cur_bit, hi;
  logic [31:0] pb_q;
  logic        ctr_b_q, tx_q, led_q, pwr_q;
  logic [31:0] buf_mem [2];
  logic        wr_ptr_q, rd_ptr_q;
  logic [1:0]  cnt_q;
  logic        in_valid, in_ready, out_valid, pop;
  logic [31:0] in_data;

  // Pin synchronisers, change accepted when stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      b_s1_q <= 4'h0;
      b_s2_q <= 4'h0;
      b_s3_q <= 4'h0;
      btn_q  <= 4'h0;
      v_s1_q <= 1'b0;
      v_s2_q <= 1'b0;
      v_s3_q <= 1'b0;
      vlow_q <= 1'b0;
    end else begin
      b_s1_q <= {button_in_3_i, button_in_2_i, button_in_1_i, button_in_0_i};
      b_s2_q <= b_s1_q;
      b_s3_q <= b_s2_q;
      if (b_s2_q == b_s3_q) btn_q <= b_s3_q;
      v_s1_q <= low_voltage_i;
      v_s2_q <= v_s1_q;
      v_s3_q <= v_s2_q;
      if (v_s2_q == v_s3_q) vlow_q <= v_s3_q;
    end
  end

  // Control decisions
  assign active_tx = (state_q == ST_WAIT) || (state_q == ST_PRE) ||
                     (state_q == ST_HDR) || (state_q == ST_DATA);
  assign tout_hit  = auto_shutoff_enable_i && (ms_q >= 32'(TIMEOUT_MS)) &&
                     (state_q != ST_IDLE) && (state_q != ST_TOUT);
  assign abort     = active_tx && (btn_q != 4'h0) && (btn_q != code_q) &&
                     !tout_hit;
  assign seed_now  = seed_enable_i && ((code_q == `SEED_IMM_CODE) ||
                     ((code_q == `SEED_DLY_CODE) &&
                      (words_q >= 10'(SEED_DELAY_WORDS))));

  always_comb begin
    go_req   = 1'b0;
    new_code = code_q;
    if ((state_q == ST_IDLE) && (btn_q != 4'h0)) begin
      go_req   = 1'b1;
      new_code = btn_q;
    end else if (abort) begin
      go_req   = 1'b1;
      new_code = btn_q;
    end else if ((state_q == ST_GUARD) && seg_end && !tout_hit &&
                 !((btn_q == 4'h0) && (words_q >= `MIN_WORDS))) begin
      go_req   = 1'b1;
      if (btn_q != 4'h0) new_code = btn_q;
    end
  end

  // Segment lengths in basic pulses
  always_comb begin
    case (state_q)
      ST_PRE:   seg_len = `PREAMBLE_TE;
      ST_HDR:   seg_len = `HEADER_TE;
      ST_DATA:  seg_len = `BIT_TE;
      ST_GUARD: seg_len = `GUARD_TE;
      default:  seg_len = 8'h01;
    endcase
  end
  assign te_end  = (te_cnt_q == 32'(TE_CYC - 1));
  assign seg_end = te_end && (unit_q == seg_len - 8'h01);

  // Two-entry buffer between cipher and serialiser
  assign in_valid       = cipher_valid_i ||
                          ((state_q == ST_REQ) && seed_now);
  assign in_data        = seed_now ? seed_word_i : cipher_data_i;
  assign in_ready       = (cnt_q != 2'h2);
  assign cipher_ready_o = in_ready;
  assign out_valid      = (cnt_q != 2'h0);
  assign pop            = out_valid && (state_q == ST_WAIT) && !abort;

  always_ff @(posedge core_clk_i) begin
    if (srst_i || abort) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      if (in_valid && in_ready) begin
        buf_mem[wr_ptr_q] <= in_data;
        wr_ptr_q          <= ~wr_ptr_q;
      end
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      cnt_q <= cnt_q + {1'b0, in_valid && in_ready} - {1'b0, pop};
    end
  end

  // Cipher request, block assembled when the code is taken
  assign cipher_req_o    = (state_q == ST_REQ) && !seed_now;
  assign plain_block_o   = pb_q;
  assign counter_b_sel_o = ctr_b_q;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pb_q    <= 32'h0;
      ctr_b_q <= 1'b0;
    end else if (go_req) begin
      ctr_b_q <= use_ctr_b(new_code, independent_counter_select_i);
      pb_q    <= {new_code, user_bit_second_i, user_bit_first_i,
                  counter_wrap_record_i, independent_counter_select_i,
                  serial_number_i[7:0],
                  use_ctr_b(new_code, independent_counter_select_i) ?
                  sync_count_b_i : sync_count_a_i};
    end
  end

  // Sequencer
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q   <= ST_IDLE;
      code_q    <= 4'h0;
      te_cnt_q  <= 32'h0;
      unit_q    <= 8'h00;
      bit_idx_q <= 7'h00;
      sr_q      <= 64'h0;
      crc_q     <= 2'h0;
      words_q   <= 10'h000;
      slot_q    <= 1'b0;
      blank_q   <= 1'b0;
    end else if (tout_hit) begin
      state_q <= ST_TOUT;
    end else if (go_req) begin
      state_q  <= ST_REQ;
      code_q   <= new_code;
      te_cnt_q <= 32'h0;
      unit_q   <= 8'h00;
      if (state_q != ST_GUARD) begin
        words_q <= 10'h000;
        slot_q  <= 1'b0;
      end
      if (state_q == ST_GUARD) slot_q <= ~slot_q;
    end else begin
      te_cnt_q <= te_end ? 32'h0 : te_cnt_q + 32'h1;
      if (te_end) unit_q <= seg_end ? 8'h00 : unit_q + 8'h01;
      case (state_q)
        ST_IDLE: begin
          te_cnt_q <= 32'h0;
        end
        ST_REQ: begin
          te_cnt_q <= 32'h0;
          if (!seed_now || in_ready) state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          te_cnt_q <= 32'h0;
          unit_q   <= 8'h00;
          if (pop) begin
            state_q   <= ST_PRE;
            bit_idx_q <= 7'h00;
            crc_q     <= 2'h0;
            blank_q   <= blank_alternate_word_i && slot_q;
            sr_q      <= {wide_serial_select_i ? serial_number_i :
                          {code_q, serial_number_i[`SER_SHORT-1:0]},
                          buf_mem[rd_ptr_q]};
          end
        end
        ST_PRE: begin
          if (seg_end) state_q <= ST_HDR;
        end
        ST_HDR: begin
          if (seg_end) state_q <= ST_DATA;
        end
        ST_DATA: begin
          if (seg_end) begin
            if (bit_idx_q <= `VLOW_IDX)
              crc_q <= crc_step(crc_q, cur_bit);
            if (bit_idx_q < `VLOW_IDX) sr_q <= sr_q >> 1;
            if (bit_idx_q == `LAST_IDX) begin
              state_q <= ST_GUARD;
              if (words_q != 10'h3ff) words_q <= words_q + 10'h001;
            end else begin
              bit_idx_q <= bit_idx_q + 7'h01;
            end
          end
        end
        ST_GUARD: begin
          if (seg_end) state_q <= ST_IDLE;
        end
        ST_TOUT: begin
          if (btn_q == 4'h0) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Shutoff timer, millisecond ticks while a transmission runs
  always_ff @(posedge core_clk_i) begin
    if (srst_i || (state_q == ST_IDLE)) begin
      tick_q <= 32'h0;
      ms_q   <= 32'h0;
    end else if (state_q != ST_TOUT) begin
      if (tick_q == 32'(TICK_CYC - 1)) begin
        tick_q <= 32'h0;
        ms_q   <= ms_q + 32'h1;
      end else begin
        tick_q <= tick_q + 32'h1;
      end
    end
  end

  // Carrier, gates the line output while independent_counter_select_i is set
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      car_cnt_q <= 32'h0;
      car_q     <= 1'b0;
    end else if (car_cnt_q == 32'(CAR_HALF - 1)) begin
      car_cnt_q <= 32'h0;
      car_q     <= ~car_q;
    end else begin
      car_cnt_q <= car_cnt_q + 32'h1;
    end
  end

  // Bit being sent, check bits last
  always_comb begin
    if (bit_idx_q < `VLOW_IDX) cur_bit = sr_q[0];
    else if (bit_idx_q == `VLOW_IDX) cur_bit = vlow_q;
    else if (bit_idx_q == `CRC_LO_IDX) cur_bit = crc_q[0];
    else cur_bit = crc_q[1];
  end

  assign hi = ((state_q == ST_PRE) && !unit_q[0]) ||
              ((state_q == ST_DATA) && ((unit_q == 8'h00) ||
               ((unit_q == 8'h01) && !cur_bit)));

  // Line outputs
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_q  <= 1'b0;
      led_q <= 1'b1;
      pwr_q <= 1'b0;
    end else begin
      tx_q  <= hi && !blank_q && !tout_hit && (state_q != ST_TOUT) &&
               (!independent_counter_select_i || car_q);
      led_q <= !((state_q == ST_PRE) || (state_q == ST_HDR) ||
                 (state_q == ST_DATA)) || tout_hit;
      pwr_q <= (state_q != ST_IDLE);
    end
  end
  assign tx_data_o    = tx_q;
  assign led_o        = led_q;
  assign power_hold_o = pwr_q;
  assign timeout_o    = (state_q == ST_TOUT);

  // Checks
  property p_order;
    @(posedge core_clk_i) disable iff (srst_i)
    $rose(state_q == ST_DATA) |-> $past(state_q) == ST_HDR;
  endproperty
  a_order: assert property (p_order) else $error("data not after header");

  property p_len;
    @(posedge core_clk_i) disable iff (srst_i)
    $rose(state_q == ST_GUARD) |-> $past(bit_idx_q) == `LAST_IDX;
  endproperty
  a_len: assert property (p_len) else $error("word length wrong");

  property p_guard;
    @(posedge core_clk_i) disable iff (srst_i)
    (state_q == ST_GUARD) ##1 (state_q == ST_GUARD) |=> !tx_q;
  endproperty
  a_guard: assert property (p_guard) else $error("output in guard");

  property p_block;
    @(posedge core_clk_i) disable iff (srst_i)
    go_req |=> pb_q[31:28] == $past(new_code) &&
               pb_q[23:16] == $past(serial_number_i[7:0]);
  endproperty
  a_block: assert property (p_block) else $error("block fields wrong");

  property p_crc;
    @(posedge core_clk_i) disable iff (srst_i)
    (state_q == ST_DATA && seg_end && bit_idx_q <= `VLOW_IDX) |=>
      crc_q == {$past(crc_q[0] ^ cur_bit),
                $past(crc_q[0] ^ cur_bit ^ crc_q[1])};
  endproperty
  a_crc: assert property (p_crc) else $error("check update wrong");

  property p_seed;
    @(posedge core_clk_i) disable iff (srst_i)
    (state_q == ST_REQ && seed_enable_i && code_q == `SEED_IMM_CODE)
      |-> !cipher_req_o;
  endproperty
  a_seed: assert property (p_seed) else $error("seed not sent");

  property p_finish;
    @(posedge core_clk_i) disable iff (srst_i)
    (state_q == ST_DATA && btn_q == 4'h0) |=> state_q != ST_IDLE;
  endproperty
  a_finish: assert property (p_finish) else $error("word cut short");

  property p_min;
    @(posedge core_clk_i) disable iff (srst_i)
    (state_q == ST_GUARD && seg_end && words_q < `MIN_WORDS && !tout_hit)
      |=> state_q == ST_REQ;
  endproperty
  a_min: assert property (p_min) else $error("stopped early");

  property p_ctr;
    @(posedge core_clk_i) disable iff (srst_i)
    (go_req && !independent_counter_select_i) |=> !counter_b_sel_o;
  endproperty
  a_ctr: assert property (p_ctr) else $error("wrong counter");

  property p_tout;
    @(posedge core_clk_i) disable iff (srst_i)
    (state_q == ST_TOUT) |=> !tx_q && led_q;
  endproperty
  a_tout: assert property (p_tout) else $error("timeout output");

  c_abort: cover property (@(posedge core_clk_i) abort);
  c_tout:  cover property (@(posedge core_clk_i) state_q == ST_TOUT);
  c_seed:  cover property (@(posedge core_clk_i)
                           state_q == ST_REQ && seed_now && in_ready);

endmodule

// File: verif/code_word_receiver.sv
// Line receiver model: decodes framed code words and checks them
`timescale 1ns/100ps
module code_word_receiver #(
  parameter int TE_CYC = 100
) (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        line_i,
  output logic      [66:0] word_o,
  output logic      [7:0]  bits_o,
  output logic             word_done_o,
  output logic             crc_ok_o,
  output logic             shape_err_o
);
  int   low_cnt;
  int   pos;
  int   guard_left;
  int   k;
  int   o;
  logic framing;

  // Check bits over bits 0..64, starting from zero
  function automatic logic [1:0] crc_of(input logic [64:0] d);
    logic [1:0] c;
    c = 2'h0;
    for (int i = 0; i < 65; i++) c = {c[0] ^ d[i], c[0] ^ d[i] ^ c[1]};
    return c;
  endfunction

  always @(posedge clk_i) begin
    word_done_o <= 1'b0;
    if (srst_i) begin
      low_cnt = 0;
      framing = 1'b0;
      guard_left = 0;
      bits_o <= 8'h00;
      shape_err_o <= 1'b0;
      crc_ok_o <= 1'b0;
    end else if (!framing) begin
      if (guard_left > 0) begin
        guard_left--;
        if (line_i) shape_err_o <= 1'b1;
      end
      if (line_i) begin
        // Only a low run of header length opens a frame
        if (low_cnt >= 9 * TE_CYC && low_cnt <= 11 * TE_CYC) begin
          framing = 1'b1;
          pos = 0;
          bits_o <= 8'h00;
        end
        low_cnt = 0;
      end else begin
        low_cnt++;
      end
    end else begin
      k = pos / (3 * TE_CYC);
      o = pos % (3 * TE_CYC);
      // A missing leading pulse means the word was cut off
      if (o == TE_CYC / 2 && !line_i) begin
        framing = 1'b0;
        low_cnt = 0;
      end
      if (o == TE_CYC + TE_CYC / 2) begin
        word_o[k] <= !line_i;
        bits_o <= 8'(k + 1);
      end
      if (o == 2 * TE_CYC + TE_CYC / 2) begin
        if (line_i) shape_err_o <= 1'b1;
        if (k == 66) begin
          framing = 1'b0;
          low_cnt = 0;
          guard_left = 38 * TE_CYC;
          word_done_o <= 1'b1;
          bits_o <= 8'h00;
          // Retry with the status bit flipped before rejecting
          crc_ok_o <= crc_of(word_o[64:0]) == word_o[66:65] ||
            crc_of({~word_o[64], word_o[63:0]}) == word_o[66:65];
        end
      end
      pos++;
    end
  end
endmodule

// File: verif/testbench.sv
// Testbench for the code word framer with a line receiver model
`timescale 1ns/100ps
module testbench;
  localparam int TE = 100;
  logic        clk, srst, vlow, indep, blank, shut, wide, seed_en;
  logic        ub1, ub2, wrap, cv, req, bsel, crdy, tx, led, hold, tout;
  logic        rx_done, rx_crc, rx_err, cipher_on;
  logic [3:0]  btn;
  logic [31:0] ser, seed, cd, pb, enc;
  logic [15:0] sa, sb;
  logic [66:0] rx_word;
  logic [7:0]  rx_bits;
  int          errors, compares, cyc, words, reqs;

  hopping_code_word_framer #(.TE_US(1), .TIMEOUT_MS(150), .TICK_CYC(100),
    .SEED_DELAY_WORDS(1)) dut (
    .core_clk_i(clk), .srst_i(srst),
    .button_in_0_i(btn[0]), .button_in_1_i(btn[1]),
    .button_in_2_i(btn[2]), .button_in_3_i(btn[3]),
    .low_voltage_i(vlow), .independent_counter_select_i(indep),
    .blank_alternate_word_i(blank), .auto_shutoff_enable_i(shut),
    .wide_serial_select_i(wide), .seed_enable_i(seed_en),
    .user_bit_first_i(ub1), .user_bit_second_i(ub2),
    .counter_wrap_record_i(wrap), .serial_number_i(ser),
    .sync_count_a_i(sa), .sync_count_b_i(sb), .seed_word_i(seed),
    .cipher_req_o(req), .plain_block_o(pb), .counter_b_sel_o(bsel),
    .cipher_valid_i(cv), .cipher_data_i(cd), .cipher_ready_o(crdy),
    .tx_data_o(tx), .led_o(led), .power_hold_o(hold), .timeout_o(tout));

  code_word_receiver #(.TE_CYC(TE)) rx (.clk_i(clk), .srst_i(srst),
    .line_i(tx), .word_o(rx_word), .bits_o(rx_bits), .word_done_o(rx_done),
    .crc_ok_o(rx_crc), .shape_err_o(rx_err));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task check(input logic [66:0] got, input logic [66:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task press(input logic [3:0] c);
    @(posedge clk);
    btn <= c;
  endtask

  task wait_done;
    repeat (32000) begin
      @(negedge clk);
      if (rx_done) break;
    end
  endtask

  function automatic logic [66:0] exp_word(input logic [31:0] e,
    input logic [3:0] c, input logic v, input logic x);
    logic [66:0] w;
    logic [1:0]  r;
    w[31:0] = e;
    w[63:32] = x ? ser : {c, ser[27:0]};
    w[64] = v;
    r = 2'h0;
    for (int i = 0; i < 65; i++) r = {r[0] ^ w[i], r[0] ^ w[i] ^ r[1]};
    w[66:65] = r;
    return w;
  endfunction

  // Cipher stand-in: answers each request while cipher_on is set, holds valid until taken
  always @(posedge clk) begin
    if (srst) cv <= 1'b0;
    else if (cv && crdy) cv <= 1'b0;
    else if (req && cipher_on) begin
      cv <= 1'b1;
      cd <= enc;
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (rx_done) words++;
    if (req) reqs++;
    if (cyc == 98000) begin
      errors++;
      stop_test();
    end
  end

  task wait_timeout;
    repeat (20000) begin
      @(negedge clk);
      if (tout) break;
    end
    check(67'(tx), 67'h0);
    check(67'(led), 67'h1);
    repeat (200) @(negedge clk);
    check(67'(tout), 67'h1);
    press(4'h0);
    repeat (10) @(negedge clk);
    check(67'({tout, hold}), 67'h0);
  endtask

  task s_normal;
    int r0;
    @(posedge clk);
    vlow <= 1'b1;
    cipher_on <= 1'b1;
    seed_en <= 1'b1;
    blank <= 1'b1;
    enc <= 32'h5a3c96e1;
    r0 = reqs;
    press(4'h3);
    repeat (5000) begin
      @(negedge clk);
      if (rx_bits >= 8'h04) break;
    end
    check(67'(led), 67'h0);
    check(67'(crdy), 67'h1);
    press(4'h0);
    wait_done();
    check(67'(rx_done), 67'h1);
    check(rx_word, exp_word(enc, 4'h3, 1'b1, 1'b0));
    @(posedge clk);
    blank <= 1'b0;
    wide <= 1'b1;
    vlow <= 1'b0;
    repeat (10 * TE) @(negedge clk);
    check(67'({led, hold}), 67'h3);
    wait_done();
    check(67'(rx_done), 67'h1);
    check(rx_word, exp_word(seed, 4'h3, 1'b0, 1'b1));
    repeat (45 * TE) @(negedge clk);
    check(67'(hold), 67'h0);
    check(67'(words), 67'h2);
    check(67'(reqs - r0), 67'h1);
    check(67'({rx_crc, rx_err}), 67'h2);
  endtask

  task s_seed;
    int r0;
    @(posedge clk);
    seed_en <= 1'b1;
    seed <= 32'h6e2b19c4;
    shut <= 1'b1;
    r0 = reqs;
    press(4'h9);
    repeat (16000) begin
      @(negedge clk);
      if (rx_bits >= 8'h20) break;
    end
    check(67'(rx_word[31:0]), 67'(seed));
    check(67'(reqs - r0), 67'h0);
    wait_timeout();
    @(posedge clk);
    seed_en <= 1'b0;
  endtask

  task s_counters;
    logic [3:0] c;
    logic       b;
    logic       got;
    int         t0;
    cipher_on <= 1'b0;
    t0 = cyc;
    for (int i = 0; i < 30; i++) begin
      c = 4'(i % 15 + 1);
      b = i >= 15 && c >= 4'h8;
      @(posedge clk);
      indep <= i >= 15;
      btn <= c;
      got = 1'b0;
      repeat (20) begin
        @(negedge clk);
        if (req) begin
          got = 1'b1;
          break;
        end
      end
      check(67'(got), 67'h1);
      repeat (2) @(negedge clk);
      check(67'(bsel), 67'(b));
      check(67'(pb), 67'({c, ub2, ub1, wrap, indep, ser[7:0],
        b ? sb : sa}));
    end
    repeat (20000) begin
      @(negedge clk);
      if (tout) break;
    end
    check(67'(cyc - t0 >= 14800 && cyc - t0 <= 15200), 67'h1);
    wait_timeout();
  endtask

  initial begin
    srst = 1'b1;
    {vlow, indep, blank, shut, wide, seed_en, cipher_on} = '0;
    {ub1, ub2, wrap} = 3'b101;
    btn = 4'h0;
    ser = 32'h89abcdef;
    seed = 32'hc3a5f00d;
    enc = 32'h0;
    sa = 16'h1234;
    sb = 16'habcd;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    s_normal();
    s_seed();
    s_counters();
    stop_test();
  end
endmodule
